// ===== hdl/sarc_pkg.sv
// Package of constants for the converter start and readout pair.
// Assumes a single 10 MHz clock shared by both ends.
package sarc_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int START_MIN_NS = 500;
  localparam int START_TYP_NS = 300;
  localparam int DONE_RISE_MAX_NS = 1500;
  localparam int CONV_MIN_NS = 10000;
  localparam int CONV_MAX_NS = 30000;
  localparam int REACQ_NS = 10000;
  localparam int START_MIN_CYC = (START_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_TYP_CYC = (START_TYP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DONE_RISE_CYC = DONE_RISE_MAX_NS / CLK_PERIOD_NS;
  localparam int CONV_MIN_CYC = (CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
  localparam int REACQ_CYC = (REACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESULT_W = 8;
  localparam int DATA_W = 16;
  localparam int STEP_CYC = 20;
  localparam logic [7:0] RESULT_RST = 8'h00;
endpackage : sarc_pkg

// ===== hdl/sarc_link_if.sv
// Interface between converter and host glue logic.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface sarc_link_if;
  logic start;
  logic done_n;
  logic output_enable_n;
  logic [7:0] result_o;
  logic [7:0] result_oe;
  logic [7:0] bus_result;
  assign bus_result = (result_oe == 8'hFF) ? result_o : 8'hFF;
  modport converter (
    input start,
    input output_enable_n,
    output done_n,
    output result_o,
    output result_oe
  );
  modport host (
    output start,
    output output_enable_n,
    input done_n,
    input bus_result
  );
endinterface : sarc_link_if

// ===== hdl/sarc_converter.sv
// Converter end: start detection, approximation sequence, readout drivers.
// Assumes start and output_enable_n synchronous to clock_i.
`timescale 1ns/100ps
// Summary of operation
// RULE1: Host holds start high at least 500 ns
// RULE2: Start pulse of 300 ns typically accepted
// RULE3: Start rise resets logic, clears result
// RULE4: Sequence begins on falling edge of start
// RULE5: Done line low when result valid
// RULE6: Done rises within 1.5 us of start
// RULE7: Conversion lasts 10 to 30 us
// RULE8: Host keeps enable high during conversion
// RULE9: Enable during conversion shows partial result
// RULE10: Drive result only while enable low
// RULE11: Start from address decode and write strobe
// RULE12: Enable from address decode and read strobe
// RULE13: Write starts conversion, data ignored
// RULE14: Read returns result as high byte
// RULE15: Without polling wait 30 us before read
// RULE16: Host may poll or interrupt on done
// RULE17: Flip-flop stretches start, done rise clears
// RULE18: Wait 10 us reacquisition before next start
// RULE19: Bipolar result is offset binary
// RULE20: Resolve MSB first, hold until next start
module sarc_converter #(
  parameter int STEP_CYC = sarc_pkg::STEP_CYC
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic comp_above_i,
  output logic [7:0] trial_o,
  sarc_link_if.converter link
);
  typedef enum logic [1:0] {
    SARC_IDLE = 2'b00,
    SARC_ARMED = 2'b01,
    SARC_CONV = 2'b10
  } sarc_state_t;

  sarc_state_t state_r;
  logic start_d_r;
  logic done_n_r;
  logic [7:0] approximation_register_r;
  logic [7:0] bit_mask_r;
  logic [7:0] step_cnt_r;
  logic start_rise;
  logic start_fall;
  logic step_end;

  assign start_rise = link.start & ~start_d_r;
  assign start_fall = ~link.start & start_d_r;
  assign step_end = (step_cnt_r == 8'(STEP_CYC - 1));

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
      start_d_r <= 1'b0;
    else
      start_d_r <= link.start;
  end

  // Pulse width only checked by edges; short pulses still work
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
      state_r <= SARC_IDLE;
    else if (start_rise)
      state_r <= SARC_ARMED; // [RULE3] [RULE2] [RULE13]
    else
      case (state_r)
        SARC_IDLE: state_r <= SARC_IDLE;
        SARC_ARMED: if (start_fall) state_r <= SARC_CONV; // [RULE4]
        SARC_CONV: if (step_end && bit_mask_r == 8'h01) state_r <= SARC_IDLE;
        default: state_r <= SARC_IDLE;
      endcase
  end

  // Done high next cycle after rise, far inside the limit
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
      done_n_r <= 1'b0;
    else if (start_rise)
      done_n_r <= 1'b1; // [RULE3] [RULE6]
    else if (state_r == SARC_CONV && step_end && bit_mask_r == 8'h01)
      done_n_r <= 1'b0; // [RULE5]
  end

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i || state_r != SARC_CONV || start_rise)
      step_cnt_r <= 8'h00;
    else if (step_end)
      step_cnt_r <= 8'h00;
    else
      step_cnt_r <= step_cnt_r + 8'h01;
  end

  // Eight steps of STEP_CYC clocks; 20 gives 16 us, inside 10..30 us
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      approximation_register_r <= sarc_pkg::RESULT_RST;
      bit_mask_r <= 8'h80;
    end
    else if (start_rise)
    begin
      approximation_register_r <= sarc_pkg::RESULT_RST; // [RULE3]
      bit_mask_r <= 8'h80;
    end
    else if (state_r == SARC_ARMED && start_fall)
      approximation_register_r <= 8'h80; // [RULE20] [RULE19]
    else if (state_r == SARC_CONV && step_end)
    begin
      // [RULE7] [RULE20]
      if (bit_mask_r == 8'h01)
        approximation_register_r <= comp_above_i ? approximation_register_r
                                                 : (approximation_register_r & ~bit_mask_r);
      else
        approximation_register_r <= (comp_above_i ? approximation_register_r
                                                  : (approximation_register_r & ~bit_mask_r))
                                    | (bit_mask_r >> 1);
      bit_mask_r <= bit_mask_r >> 1;
    end
  end

  assign trial_o = approximation_register_r;
  assign link.done_n = done_n_r;
  // Partial value visible if enabled mid-conversion: bus clash risk
  assign link.result_o = approximation_register_r; // [RULE9] [RULE14]
  assign link.result_oe = {8{~link.output_enable_n}}; // [RULE10]
endmodule : sarc_converter

// ===== hdl/sarc_host.sv
// Host glue end: start stretching, enable gating, result capture.
// Assumes bus strobes synchronous to clock_i and active high.
`timescale 1ns/100ps
module sarc_host (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic addr_hit_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic use_done_i,
  output logic [15:0] rdata_o,
  output logic ready_o,
  output logic done_irq_o,
  sarc_link_if.host link
);
  logic start_r;
  logic done_d_r;
  logic [11:0] wait_cnt_r;
  logic [15:0] rdata_r;
  logic [7:0] width_cnt_r;
  logic done_rise;
  logic done_fall;

  assign done_rise = link.done_n & ~done_d_r;
  assign done_fall = ~link.done_n & done_d_r;

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
      done_d_r <= 1'b0;
    else
      done_d_r <= link.done_n;
  end

  // Stretched pulse: ends on done rise, but never below minimum width
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      start_r <= 1'b0;
      width_cnt_r <= 8'h00;
    end
    else if (addr_hit_i && wr_i && ready_o && !start_r)
    begin
      start_r <= 1'b1; // [RULE11] [RULE13] [RULE17]
      width_cnt_r <= 8'h00;
    end
    else if (start_r)
    begin
      if (width_cnt_r != 8'hFF)
        width_cnt_r <= width_cnt_r + 8'h01;
      if (link.done_n && width_cnt_r >= 8'(sarc_pkg::START_MIN_CYC - 1))
        start_r <= 1'b0; // [RULE1] [RULE17]
    end
  end

  // Counts conversion wait, then reacquisition time if use_done_i is set
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
      wait_cnt_r <= 12'h000;
    else if (start_r)
      wait_cnt_r <= 12'(sarc_pkg::CONV_MAX_CYC); // [RULE15]
    else if (use_done_i && done_fall)
      wait_cnt_r <= 12'(sarc_pkg::REACQ_CYC); // [RULE18] [RULE16]
    else if (wait_cnt_r != 12'h000)
      wait_cnt_r <= wait_cnt_r - 12'h001;
  end

  assign ready_o = (wait_cnt_r == 12'h000) && !start_r && !done_rise
                   && !(use_done_i && link.done_n);
  assign done_irq_o = done_fall; // [RULE16]
  // Enable only on a read when not converting
  assign link.output_enable_n = ~(addr_hit_i && rd_i && ready_o); // [RULE12] [RULE8]
  assign link.start = start_r;

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
      rdata_r <= 16'h0000;
    else if (addr_hit_i && rd_i && ready_o)
      rdata_r <= {link.bus_result, 8'h00}; // [RULE14]
  end
  assign rdata_o = rdata_r;
endmodule : sarc_host

// ===== test/sarc_asserts.sv
// Checker on the link between converter and host glue.
// Assumes one clock domain shared by both ends.
`timescale 1ns/100ps
module sarc_asserts (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic start,
  input wire logic done_n,
  input wire logic output_enable_n,
  input wire logic [7:0] result_o,
  input wire logic [7:0] result_oe
);
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);
  // Done must rise within 15 cycles, i.e. 1.5 us
  sequence s_rise_seen;
    ##[1:15] done_n;
  endsequence
  // Conversion spans 10 to 30 us
  sequence s_conv_end;
    ##[100:300] $fell(done_n);
  endsequence
  AST_DONE_RISE: assert property ($rose(start) |-> s_rise_seen)
    else $error("done line late after start");
  AST_START_WIDTH: assert property ($rose(start) |-> start [*5])
    else $error("start pulse too short");
  AST_CONV_TIME: assert property ($fell(start) |-> s_conv_end)
    else $error("conversion time out of range");
  AST_NO_EARLY: assert property ($fell(done_n) |-> !$past(start))
    else $error("done fell while start high");
  AST_RISE_ON_START: assert property ($rose(done_n) |-> start)
    else $error("done rose without start");
  AST_OE_OFF: assert property (output_enable_n |-> result_oe == 8'h00)
    else $error("result driven while disabled");
  AST_OE_ON: assert property (!output_enable_n |-> result_oe == 8'hFF)
    else $error("result not driven while enabled");
  AST_CLEAR: assert property ($rose(start) |-> ##[1:5] result_o == 8'h00)
    else $error("old result not cleared");
  AST_HOLD: assert property (!done_n && !start |=> $stable(result_o))
    else $error("result changed while held");
  // Glue must drop start soon after done rises, else no conversion begins
  AST_START_CLEAR: assert property ($rose(done_n) |-> ##[1:8] !start)
    else $error("start not cleared after done rose");
endmodule : sarc_asserts

// ===== test/sar_adc_start_and_readout_test.sv
// Bench joining converter and host glue through the link interface.
// Assumes the default step length, so conversions take 160 cycles.
`timescale 1ns/100ps
module sar_adc_start_and_readout_test;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic addr_hit_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic use_done_i = 1'b0;
  logic comp_above_i = 1'b0;
  logic [7:0] vin = 8'h00;
  logic [7:0] trial_o;
  logic [15:0] rdata_o;
  logic ready_o;
  logic done_irq_o;
  logic [7:0] codes [4] = '{8'h00, 8'h80, 8'hFF, 8'h5A};
  int fail_count = 0;
  int compares = 0;
  sarc_link_if sarc_link_if_inst ();
  sarc_converter sarc_converter_inst (.clock_i, .nrst_i, .comp_above_i, .trial_o,
    .link(sarc_link_if_inst.converter));
  sarc_host sarc_host_inst (.clock_i, .nrst_i, .addr_hit_i, .wr_i, .rd_i, .use_done_i,
    .rdata_o, .ready_o, .done_irq_o, .link(sarc_link_if_inst.host));
  sarc_asserts sarc_asserts_inst (.clock_i, .nrst_i, .start(sarc_link_if_inst.start),
    .done_n(sarc_link_if_inst.done_n), .output_enable_n(sarc_link_if_inst.output_enable_n),
    .result_o(sarc_link_if_inst.result_o), .result_oe(sarc_link_if_inst.result_oe));
  always #50 clock_i = ~clock_i;
  // Ideal comparator; converges on vin
  always @(posedge clock_i) comp_above_i <= (trial_o <= vin);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish
  // Holds the strobe until an edge sees ready high
  task automatic acc(input logic w);
    int n;
    n = 0;
    @(posedge clock_i);
    addr_hit_i <= 1'b1;
    wr_i <= w;
    rd_i <= !w;
    #1;
    while (ready_o !== 1'b1 && n < 1000)
    begin
      @(posedge clock_i);
      #1;
      n++;
    end
    chk(16'(n < 1000), 16'h0001);
    @(posedge clock_i);
    addr_hit_i <= 1'b0;
    wr_i <= 1'b0;
    rd_i <= 1'b0;
  endtask : acc
  initial
  begin
    repeat (5) @(posedge clock_i);
    nrst_i <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clock_i);
      vin <= codes[i % 4];
      use_done_i <= i[0];
      acc(1'b1);
      if (i[0])
      begin
        // Poll the done pulse, bounded by 400 cycles, above the 300-cycle longest conversion
        for (int n = 0; n < 400 && done_irq_o !== 1'b1; n++) @(posedge clock_i) #1;
        chk(16'(done_irq_o), 16'h0001);
        repeat (100) @(posedge clock_i);
      end
      chk(8'(sarc_link_if_inst.bus_result), 8'hFF);
      acc(1'b0);
      #1;
      chk(rdata_o, {codes[i % 4], 8'h00});
      chk(16'(sarc_link_if_inst.done_n), 16'h0000);
      chk(16'(trial_o), 16'(codes[i % 4]));
      $display("test %0d done, code %h", i, codes[i % 4]);
    end
    tally_and_finish();
  end
  initial
  begin
    repeat (6000) @(posedge clock_i);
    fail_count++;
    tally_and_finish();
  end
endmodule : sar_adc_start_and_readout_test
